// ### include/msic_params.svh
// register offsets, field positions, reset values of the monitor register bank
`ifndef MSIC_PARAMS_SVH
`define MSIC_PARAMS_SVH

// ----------------------------------------------------------------
// pages and offsets
// ----------------------------------------------------------------
`define MSIC_PAGE_USER  1'b0
`define MSIC_PAGE_OEM   1'b1
`define MSIC_OFS_CFG0   8'h00
`define MSIC_OFS_RDY    8'hfe
`define MSIC_OFS_UCTL   8'hff

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MSIC_RST_CFG0   8'h00
`define MSIC_RST_RDY    8'h00
`define MSIC_RST_UCTL   8'h20

// ----------------------------------------------------------------
// ready flags: temp, volt, bias, tx, rx on bits 7..3
// ----------------------------------------------------------------
`define MSIC_NRDY       5
`define MSIC_RDY_LSB    3

// ----------------------------------------------------------------
// user control fields
// ----------------------------------------------------------------
`define MSIC_UC_MASK    6
`define MSIC_UC_FLAG    5
`define MSIC_UC_IE      4
`define MSIC_UC_SEL_HI  3
`define MSIC_UC_SEL_LO  2

// ----------------------------------------------------------------
// analog config 0 fields
// ----------------------------------------------------------------
`define MSIC_C0_RST     7
`define MSIC_C0_ZONE    6
`define MSIC_C0_DIODE_FAULT_FLAG    5
`define MSIC_C0_OE      4
`define MSIC_C0_MODULATION_REFERENCE_SELECT  3
`define MSIC_C0_AUX_VOLTAGE_SELECT_HI 2
`define MSIC_C0_AUX_VOLTAGE_SELECT_LO 0

// ----------------------------------------------------------------
// non-volatile image layout
// ----------------------------------------------------------------
`define MSIC_NV_W       10
`define MSIC_NV_USR_LO  6

`endif

// ### include/msic_pkg.sv
// types shared by the monitor register bank modules
package msic_pkg;

    // ----------------------------------------------------------------
    // byte and non-volatile field groups
    // ----------------------------------------------------------------
    typedef logic [7:0] msic_byte_type;

    typedef struct packed {
        logic       mask;   // power-on irq mask
        logic       ie;     // global irq allow
        logic [1:0] sel;    // setpoint select
    } msic_user_nv_type;

    typedef struct packed {
        logic       zone;   // temp zone, 1 = external
        logic       oe;     // drive outputs enabled
        logic       modulation_reference_select; // modulation ref, 1 = supply
        logic [2:0] aux_voltage_select;   // aux voltage select
    } msic_oem_nv_type;

endpackage

// ### include/msic_nv_if.sv
// carrier between register logic and non-volatile store
`timescale 1ns/1ps
interface msic_nv_if;
    import msic_pkg::*;

    logic             user_wr; // write strobe, user control
    logic             oem_wr;  // write strobe, analog config 0
    msic_byte_type    wdata;   // written byte
    msic_user_nv_type user;    // held user fields
    msic_oem_nv_type  oem;     // held analog fields

    modport regs  (output user_wr, oem_wr, wdata, input user, oem);
    modport store (input user_wr, oem_wr, wdata, output user, oem);
endinterface

// ### rtl/msic_nvstore.sv
// non-volatile field store, loaded from the image under reset
`timescale 1ns/1ps
`include "msic_params.svh"
module msic_nvstore
    import msic_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic [`MSIC_NV_W-1:0] nv_image,
    output logic      [`MSIC_NV_W-1:0] nv_image_q,
    output logic                       nv_save_q,
    msic_nv_if.store                   nv
);

    // ----------------------------------------------------------------
    // field storage
    // ----------------------------------------------------------------
    msic_user_nv_type user_q; // held user fields
    msic_oem_nv_type  oem_q;  // held analog fields
    msic_user_nv_type user_d; // next user fields
    msic_oem_nv_type  oem_d;  // next analog fields

    // next values from the write strobes
    always_comb begin
        user_d = user_q;
        oem_d  = oem_q;
        if (nv.user_wr) begin
            user_d.mask = nv.wdata[`MSIC_UC_MASK];
            user_d.ie   = nv.wdata[`MSIC_UC_IE];
            user_d.sel  = nv.wdata[`MSIC_UC_SEL_HI:`MSIC_UC_SEL_LO];
        end
        if (nv.oem_wr) begin
            oem_d.zone   = nv.wdata[`MSIC_C0_ZONE];
            oem_d.oe     = nv.wdata[`MSIC_C0_OE];
            oem_d.modulation_reference_select = nv.wdata[`MSIC_C0_MODULATION_REFERENCE_SELECT];
            oem_d.aux_voltage_select   = nv.wdata[`MSIC_C0_AUX_VOLTAGE_SELECT_HI:`MSIC_C0_AUX_VOLTAGE_SELECT_LO];
        end
    end

    // fields reload from the stored image while reset holds
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            user_q <= msic_user_nv_type'(nv_image[`MSIC_NV_W-1:`MSIC_NV_USR_LO]);
            oem_q  <= msic_oem_nv_type'(nv_image[`MSIC_NV_USR_LO-1:0]);
        end else begin
            user_q <= user_d;
            oem_q  <= oem_d;
        end
    end

    // save request with the fresh image after each write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nv_save_q  <= 1'b0;
            nv_image_q <= '0;
        end else begin
            nv_save_q  <= nv.user_wr | nv.oem_wr;
            nv_image_q <= {user_d, oem_d};
        end
    end

    assign nv.user = user_q;
    assign nv.oem  = oem_q;

endmodule

// ### rtl/msic_regs.sv
// status, user control and analog config register bank of the monitor
`timescale 1ns/1ps
`include "msic_params.svh"
module msic_regs
    import msic_pkg::*;
#(
    parameter int NRDY = `MSIC_NRDY
)
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  acc_req,
    input  wire logic                  acc_write,
    input  wire logic                  acc_page,
    input  wire logic [7:0]            acc_addr,
    input  wire logic [7:0]            acc_wdata,
    input  wire logic                  user_pw_ok,
    input  wire logic                  oem_pw_ok,
    input  wire logic [NRDY-1:0]       conv_done,
    input  wire logic [NRDY-1:0]       result_read,
    input  wire logic                  diode_fault,
    input  wire logic [`MSIC_NV_W-1:0] nv_image,
    output logic                       rd_valid_q,
    output logic      [7:0]            rd_data_q,
    output logic                       irq_n_q,
    output logic                       warm_reset_q,
    output logic                       pw_apply_q,
    output logic                       adc_restart_q,
    output logic      [1:0]            setpoint_select_q,
    output logic                       temp_zone_ext_q,
    output logic                       drive_enable_q,
    output logic                       mod_ref_vdd_q,
    output logic      [2:0]            aux_voltage_select_q,
    output logic                       nv_save_q,
    output logic      [`MSIC_NV_W-1:0] nv_image_q
);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------

    // page and offset match, used for every register
    function automatic logic hit(input logic pg, input logic [7:0] ad,
                                 input logic wpg, input logic [7:0] wad);
        return (pg == wpg) && (ad == wad);
    endfunction

    logic hit_rdy;   // ready flags selected
    logic hit_uctl;  // user control selected
    logic hit_cfg;   // analog config 0 selected
    logic uctl_ok;   // user control unlocked
    logic wr_uctl;   // accepted user control write
    logic rd_uctl;   // accepted user control read
    logic wr_cfg;    // accepted config write
    logic rst_trig;  // config write with reset bit

    assign hit_rdy  = hit(acc_page, acc_addr, `MSIC_PAGE_USER, `MSIC_OFS_RDY);
    assign hit_uctl = hit(acc_page, acc_addr, `MSIC_PAGE_USER, `MSIC_OFS_UCTL);
    assign hit_cfg  = hit(acc_page, acc_addr, `MSIC_PAGE_OEM, `MSIC_OFS_CFG0);

    // manufacturer password also opens user space
    assign uctl_ok  = user_pw_ok | oem_pw_ok;
    assign wr_uctl  = acc_req & acc_write & hit_uctl & uctl_ok;
    assign rd_uctl  = acc_req & ~acc_write & hit_uctl & uctl_ok;
    assign wr_cfg   = acc_req & acc_write & hit_cfg & oem_pw_ok;
    assign rst_trig = wr_cfg & acc_wdata[`MSIC_C0_RST];

    // ----------------------------------------------------------------
    // non-volatile fields
    // ----------------------------------------------------------------
    msic_nv_if nv ();

    // only the stored fields reach the store; flag and reset bit do not
    assign nv.user_wr = wr_uctl;
    assign nv.oem_wr  = wr_cfg;
    assign nv.wdata   = acc_wdata;

    msic_nvstore u_store (
        .clk        (clk),
        .rst_n      (rst_n),
        .nv_image   (nv_image),
        .nv_image_q (nv_image_q),
        .nv_save_q  (nv_save_q),
        .nv         (nv.store)
    );

    // control outputs straight from the stored fields
    assign setpoint_select_q    = nv.user.sel;
    assign temp_zone_ext_q      = nv.oem.zone;
    assign drive_enable_q       = nv.oem.oe;
    assign mod_ref_vdd_q        = nv.oem.modulation_reference_select;
    assign aux_voltage_select_q = nv.oem.aux_voltage_select;

    // ----------------------------------------------------------------
    // power-on detection
    // ----------------------------------------------------------------
    logic por_pend_q; // high for one cycle after release
    logic por_event;  // power-on event pulse

    // power-on is the first cycle after reset release
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            por_pend_q <= 1'b1;
        end else begin
            por_pend_q <= 1'b0;
        end
    end

    assign por_event = por_pend_q;

    // ----------------------------------------------------------------
    // conversion ready flags
    // ----------------------------------------------------------------
    logic [NRDY-1:0] rdy_q;     // ready flags
    logic [NRDY-1:0] rdy_d;     // next ready flags
    logic [NRDY-1:0] done_ok;   // completions not discarded
    logic [NRDY-1:0] clr_only;  // clears without a new result

    // a config write drops the result finishing in that cycle
    assign done_ok  = conv_done & ~{NRDY{wr_cfg}};
    assign clr_only = result_read & ~done_ok;

    // set wins over the clearing read in the same cycle
    always_comb begin
        rdy_d = (rdy_q & ~result_read) | done_ok;
    end

    // flag storage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdy_q <= NRDY'(`MSIC_RST_RDY >> `MSIC_RDY_LSB);
        end else begin
            rdy_q <= rdy_d;
        end
    end

    // ----------------------------------------------------------------
    // power-on interrupt flag and output
    // ----------------------------------------------------------------
    logic flag_q;   // power-on interrupt flag
    logic flag_d;   // next flag
    logic mute_q;   // output silenced by allow write
    logic mute_d;   // next mute
    logic irq_on;   // interrupt condition

    // power-on sets when masked in; a read clears; set wins
    always_comb begin
        flag_d = flag_q;
        if (rd_uctl) begin
            flag_d = 1'b0;
        end
        if (por_event && nv.user.mask) begin
            flag_d = 1'b1;
        end
    end

    // allow written as one silences a live interrupt until flag clears
    always_comb begin
        mute_d = mute_q;
        if (!flag_d) begin
            mute_d = 1'b0;
        end else if (wr_uctl && acc_wdata[`MSIC_UC_IE] && !irq_n_q) begin
            mute_d = 1'b1;
        end
    end

    // mask and allow gate the flag; warm reset never sets it
    assign irq_on = flag_q & nv.user.mask & nv.user.ie & ~mute_q;

    // flag, mute and active-low interrupt registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flag_q  <= 1'b0;
            mute_q  <= 1'b0;
            irq_n_q <= 1'b1;
        end else begin
            flag_q  <= flag_d;
            mute_q  <= mute_d;
            irq_n_q <= ~irq_on;
        end
    end

    // ----------------------------------------------------------------
    // config write side effects
    // ----------------------------------------------------------------

    // abort and restart, warm reset and password apply pulses
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            adc_restart_q <= 1'b0;
            warm_reset_q  <= 1'b0;
            pw_apply_q    <= 1'b0;
        end else begin
            adc_restart_q <= wr_cfg;
            warm_reset_q  <= rst_trig;
            pw_apply_q    <= por_event | rst_trig;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    logic [7:0] rd_mux; // selected read byte

    // reserved bits and locked or unmapped bytes read zero
    always_comb begin
        rd_mux = 8'h00;
        if (hit_rdy) begin
            rd_mux[7:`MSIC_RDY_LSB] = rdy_q;
        end else if (hit_uctl && uctl_ok) begin
            rd_mux[`MSIC_UC_MASK] = nv.user.mask;
            rd_mux[`MSIC_UC_FLAG] = flag_q;
            rd_mux[`MSIC_UC_IE]   = nv.user.ie;
            rd_mux[`MSIC_UC_SEL_HI:`MSIC_UC_SEL_LO] = nv.user.sel;
        end else if (hit_cfg && oem_pw_ok) begin
            rd_mux[`MSIC_C0_ZONE]   = nv.oem.zone;
            rd_mux[`MSIC_C0_DIODE_FAULT_FLAG]   = diode_fault;
            rd_mux[`MSIC_C0_OE]     = nv.oem.oe;
            rd_mux[`MSIC_C0_MODULATION_REFERENCE_SELECT] = nv.oem.modulation_reference_select;
            rd_mux[`MSIC_C0_AUX_VOLTAGE_SELECT_HI:`MSIC_C0_AUX_VOLTAGE_SELECT_LO] = nv.oem.aux_voltage_select;
        end
    end

    // read answer one cycle after the request
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_valid_q <= 1'b0;
            rd_data_q  <= 8'h00;
        end else begin
            rd_valid_q <= acc_req & ~acc_write;
            rd_data_q  <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic       cfg_locked; // config write without password
    logic [1:0] wd_sel;     // written setpoint code
    logic [2:0] wd_aux_voltage_select;    // written aux code

    assign cfg_locked = acc_req & acc_write & hit_cfg & ~oem_pw_ok;
    assign wd_sel     = acc_wdata[`MSIC_UC_SEL_HI:`MSIC_UC_SEL_LO];
    assign wd_aux_voltage_select    = acc_wdata[`MSIC_C0_AUX_VOLTAGE_SELECT_HI:`MSIC_C0_AUX_VOLTAGE_SELECT_LO];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_rdy_set: assert property (
        1'b1 |=> ((rdy_q & $past(done_ok)) == $past(done_ok)))
        else $error("ready flag not set after conversion");

    chk_rdy_clear: assert property (
        1'b1 |=> ((rdy_q & $past(clr_only)) == '0))
        else $error("ready flag not cleared by result read");

    chk_rdy_layout: assert property (
        acc_req && !acc_write && hit_rdy
        |=> rd_valid_q && rd_data_q == {$past(rdy_q), 3'h0})
        else $error("ready flag byte layout wrong");

    chk_irq_gate: assert property (
        !nv.user.ie |=> irq_n_q)
        else $error("interrupt with global allow clear");

    chk_flag_por: assert property (
        por_event && nv.user.mask |=> flag_q)
        else $error("power-on flag not set");

    chk_warm_noirq: assert property (
        rst_trig && !flag_q && !por_event |=> !flag_q ##1 irq_n_q)
        else $error("warm reset raised power-on interrupt");

    chk_read_clear: assert property (
        rd_uctl && !por_event |=> !flag_q ##1 irq_n_q)
        else $error("user control read did not clear");

    chk_allow_mute: assert property (
        wr_uctl && acc_wdata[`MSIC_UC_IE] && !irq_n_q && !por_event
        |=> ##1 irq_n_q)
        else $error("allow write did not drop interrupt");

    chk_flag_hold: assert property (
        flag_q && !rd_uctl |=> flag_q)
        else $error("power-on flag lost without read");

    chk_sel_write: assert property (
        wr_uctl |=> setpoint_select_q == $past(wd_sel))
        else $error("setpoint select not stored");

    chk_uctl_lock: assert property (
        acc_req && acc_write && hit_uctl && !uctl_ok
        |=> $stable(setpoint_select_q) && !nv_save_q)
        else $error("locked user control written");

    chk_restart: assert property (
        wr_cfg |=> adc_restart_q && aux_voltage_select_q == $past(wd_aux_voltage_select))
        else $error("config write lost or no restart");

    chk_cfg_lock: assert property (
        cfg_locked |=> !adc_restart_q && !warm_reset_q)
        else $error("locked config written");

    chk_warm_reset: assert property (
        rst_trig |=> warm_reset_q && pw_apply_q)
        else $error("reset bit did not start warm reset");

    chk_no_warm: assert property (
        !rst_trig |=> !warm_reset_q)
        else $error("warm reset without trigger");

    chk_pw_por: assert property (
        por_event |=> pw_apply_q)
        else $error("password not applied at power-on");

endmodule

// ### tb/msic_host_model.sv
// host model driving the register access port of the monitor bank
`timescale 1ns/1ps
module msic_host_model (
    input  wire logic       clk,
    output logic            acc_req,
    output logic            acc_write,
    output logic            acc_page,
    output logic [7:0]      acc_addr,
    output logic [7:0]      acc_wdata,
    input  wire logic       rd_valid_q,
    input  wire logic [7:0] rd_data_q
);
    // ----------------------------------------------------------------
    // idle bus at time zero
    // ----------------------------------------------------------------
    initial begin
        acc_req   = 1'b0;
        acc_write = 1'b0;
        acc_page  = 1'b0;
        acc_addr  = 8'h00;
        acc_wdata = 8'h00;
    end

    // one byte access, launched after a falling edge, taken at the rising edge
    task automatic access(input logic wr, input logic pg, input logic [7:0] ad,
                          input logic [7:0] wd);
        @(negedge clk);
        acc_req   = 1'b1;
        acc_write = wr;
        acc_page  = pg;
        acc_addr  = ad;
        acc_wdata = wd; // reserved bits written as zero by callers, except the ff write to the ready byte
        @(negedge clk);
        // released write, address and data lines show the inverse; page keeps its value
        acc_req   = 1'b0;
        acc_write = ~wr;
        acc_addr  = ~ad;
        acc_wdata = ~wd;
    endtask

    // read one byte; waits for the answer under a bounded count
    task automatic rd(input logic pg, input logic [7:0] ad,
                      output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d  = 8'h00;
        access(1'b0, pg, ad, 8'h00); // power-on flag cleared by a user control read
        for (int i = 0; i < 3 && !ok; i++) begin
            if (rd_valid_q === 1'b1) begin
                ok = 1'b1;
                d  = rd_data_q;
            end else begin
                @(negedge clk);
            end
        end
    endtask
endmodule

// ### tb/msic_regs_tb_top.sv
// self-checking bench for the monitor register bank
`timescale 1ns/1ps
`include "msic_params.svh"
module msic_regs_tb_top;
    import msic_pkg::*;

    // ----------------------------------------------------------------
    // design signals
    // ----------------------------------------------------------------
    logic       clk, rst_n, acc_req, acc_write, acc_page;
    logic [7:0] acc_addr, acc_wdata, rd_data_q;
    logic       user_pw_ok, oem_pw_ok, diode_fault, rd_valid_q, irq_n_q;
    logic [4:0] conv_done, result_read;
    logic [9:0] nv_image, nv_image_q;
    logic       warm_reset_q, pw_apply_q, adc_restart_q, nv_save_q;
    logic [1:0] setpoint_select_q;
    logic       temp_zone_ext_q, drive_enable_q, mod_ref_vdd_q;
    logic [2:0] aux_voltage_select_q;
    int         errors, n_checks, n_warm, n_rst, n_pw, n_sv, w0, r0, p0, v0;

    msic_regs uut (
        .clk(clk), .rst_n(rst_n), .acc_req(acc_req), .acc_write(acc_write),
        .acc_page(acc_page), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .user_pw_ok(user_pw_ok), .oem_pw_ok(oem_pw_ok), .conv_done(conv_done),
        .result_read(result_read), .diode_fault(diode_fault), .nv_image(nv_image),
        .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q), .irq_n_q(irq_n_q),
        .warm_reset_q(warm_reset_q), .pw_apply_q(pw_apply_q),
        .adc_restart_q(adc_restart_q), .setpoint_select_q(setpoint_select_q),
        .temp_zone_ext_q(temp_zone_ext_q), .drive_enable_q(drive_enable_q),
        .mod_ref_vdd_q(mod_ref_vdd_q), .aux_voltage_select_q(aux_voltage_select_q),
        .nv_save_q(nv_save_q), .nv_image_q(nv_image_q)
    );

    msic_host_model host (
        .clk(clk), .acc_req(acc_req), .acc_write(acc_write), .acc_page(acc_page),
        .acc_addr(acc_addr), .acc_wdata(acc_wdata), .rd_valid_q(rd_valid_q),
        .rd_data_q(rd_data_q)
    );

    // ----------------------------------------------------------------
    // clock and pulse counters
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // count one-cycle pulses so missing or doubled ones show
    always @(posedge clk) begin
        if (rst_n === 1'b1) begin
            n_warm += (warm_reset_q === 1'b1);
            n_rst  += (adc_restart_q === 1'b1);
            n_pw   += (pw_apply_q === 1'b1);
            n_sv   += (nv_save_q === 1'b1);
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic finish_test;
        if (errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // compare one value, report a mismatch at once
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // read and compare; a missing answer ends the run
    task automatic rdc(input logic pg, input logic [7:0] ad, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        host.rd(pg, ad, d, ok);
        if (!ok) begin
            errors++;
            finish_test();
        end else begin
            chk(d, exp);
        end
    endtask

    // power-on reset held 16 cycles with a given stored image
    task automatic do_reset(input logic [9:0] nv);
        @(negedge clk);
        nv_image = nv;
        rst_n    = 1'b0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask

    task automatic settle;
        repeat (3) @(negedge clk);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {user_pw_ok, oem_pw_ok, diode_fault} = 3'b000;
        {conv_done, result_read} = 10'h000;
        {errors, n_checks, n_warm, n_rst, n_pw, n_sv} = '0;
        rst_n    = 1'b0;
        nv_image = 10'h000;
        // image: mask 1, allow 1, select 10, zone 1, oe 0, modulation_reference_select 1, aux 101
        do_reset(10'b11_10_1_0_1_101);
        chk(8'(setpoint_select_q), 8'h02);
        chk(8'(temp_zone_ext_q), 8'h01);
        chk(8'(drive_enable_q), 8'h00);
        chk(8'(mod_ref_vdd_q), 8'h01);
        chk(8'(aux_voltage_select_q), 8'h05);
        chk(8'(irq_n_q), 8'h00);
        rdc(1'b0, `MSIC_OFS_UCTL, 8'h00); // locked without password
        // locked write must leave the stored fields alone, seen by the next read
        host.access(1'b1, 1'b0, `MSIC_OFS_UCTL, 8'h00);
        user_pw_ok = 1'b1;
        rdc(1'b0, `MSIC_OFS_UCTL, 8'h78);
        settle();
        chk(8'(irq_n_q), 8'h01);
        rdc(1'b0, `MSIC_OFS_UCTL, 8'h58);
        // each ready flag set by its conversion, cleared by its result read
        for (int i = 0; i < 5; i++) begin
            @(negedge clk);
            conv_done[4-i] = 1'b1;
            @(negedge clk);
            conv_done = 5'h00;
            rdc(1'b0, `MSIC_OFS_RDY, 8'h80 >> i);
            @(negedge clk);
            result_read[4-i] = 1'b1;
            @(negedge clk);
            result_read = 5'h00;
            rdc(1'b0, `MSIC_OFS_RDY, 8'h00);
        end
        host.access(1'b1, 1'b0, `MSIC_OFS_RDY, 8'hff);
        rdc(1'b0, `MSIC_OFS_RDY, 8'h00); // read-only flags
        // every setpoint code, mask and allow kept set
        for (int s = 0; s < 4; s++) begin
            host.access(1'b1, 1'b0, `MSIC_OFS_UCTL, 8'h50 | 8'(s << 2));
            settle();
            chk(8'(setpoint_select_q), 8'(s));
        end
        // config locked without manufacturer password
        host.access(1'b1, 1'b1, `MSIC_OFS_CFG0, 8'h9a);
        settle();
        chk(8'(aux_voltage_select_q), 8'h05);
        rdc(1'b1, `MSIC_OFS_CFG0, 8'h00);
        oem_pw_ok = 1'b1;
        {w0, r0, p0, v0} = {n_warm, n_rst, n_pw, n_sv};
        host.access(1'b1, 1'b1, `MSIC_OFS_CFG0, 8'h9a);
        settle();
        chk(8'(n_warm - w0), 8'h01);
        chk(8'(n_rst - r0), 8'h01);
        chk(8'(n_pw - p0), 8'h01);
        chk(8'({temp_zone_ext_q, drive_enable_q, mod_ref_vdd_q}), 8'h03);
        // one save request, image holds user 1_1_11 and config 0_1_1_010
        chk(8'(n_sv - v0), 8'h01);
        chk(nv_image_q[7:0], 8'hda);
        chk(8'(nv_image_q[9:8]), 8'h03);
        diode_fault = 1'b1;
        settle();
        rdc(1'b1, `MSIC_OFS_CFG0, 8'h3a); // reset bit reads 0
        // aux voltage codes 0 to 6 with reset bit 0
        for (int v = 0; v < 7; v++) begin
            host.access(1'b1, 1'b1, `MSIC_OFS_CFG0, 8'h40 | 8'(v));
            settle();
            chk(8'(aux_voltage_select_q), 8'(v));
            chk(8'(temp_zone_ext_q), 8'h01);
        end
        chk(8'(n_warm - w0), 8'h01);
        chk(8'(n_rst - r0), 8'h08);
        chk(8'(n_sv - v0), 8'h08);
        chk(8'(irq_n_q), 8'h01); // no interrupt after warm reset
        rdc(1'b0, `MSIC_OFS_UCTL, 8'h5c);
        // a result finishing in the cycle of a config write is dropped
        fork
            host.access(1'b1, 1'b1, `MSIC_OFS_CFG0, 8'h46);
            begin
                @(negedge clk);
                conv_done[0] = 1'b1;
                @(negedge clk);
                conv_done = 5'h00;
            end
        join
        rdc(1'b0, `MSIC_OFS_RDY, 8'h00);
        // allow written while interrupt active
        do_reset(10'b11_00_0_0_0_000);
        chk(8'(irq_n_q), 8'h00);
        host.access(1'b1, 1'b0, `MSIC_OFS_UCTL, 8'h50);
        settle();
        chk(8'(irq_n_q), 8'h01);
        rdc(1'b0, `MSIC_OFS_UCTL, 8'h70); // flag still pending
        // allow off at power-on, turned on later
        do_reset(10'b10_00_0_0_0_000);
        chk(8'(irq_n_q), 8'h01);
        host.access(1'b1, 1'b0, `MSIC_OFS_UCTL, 8'h50);
        settle();
        chk(8'(irq_n_q), 8'h00);
        rdc(1'b0, `MSIC_OFS_UCTL, 8'h70);
        settle();
        chk(8'(irq_n_q), 8'h01);
        finish_test();
    end
endmodule
